// ### design/ttm_pkg.sv
// package of constants and carriers for the tracking timebase block
// assumes a single 125 MHz core clock and plain-port control
//------------------------------------------------------------
//------------------------------------------------------------
package ttm_pkg;
    localparam int CLK_PERIOD_PS      = 8000;
    localparam int BASE_TICK_PS       = 175000;
    localparam int BASE_TICK_CYC      = (BASE_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int IRQ_DEFAULT_TICKS  = 2886;
    localparam int STROBE_100MS_IRQS  = 198;
    localparam int STROBE_9MS_IRQS    = 18;
    localparam int RTC_TICK_PS        = 2275000;
    localparam int RTC_TICK_CYC       = RTC_TICK_PS / CLK_PERIOD_PS;
    localparam int MARK_STEP_PS       = 50000;
    localparam int MARK_STEP_CYC      = MARK_STEP_PS / CLK_PERIOD_PS;
    localparam int MARK_FIXED_PS      = 25000;
    localparam int MARK_FIXED_CYC     = (MARK_FIXED_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CORR_DELAY_PS      = 100000;
    localparam int STROBE_PHASE_PS    = 25000;
    localparam int STROBE_PHASE_CYC   = (STROBE_PHASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int EPOCH_READ_PS      = 1000000000;
    localparam int EPOCH_READ_CYC     = EPOCH_READ_PS / CLK_PERIOD_PS;
    localparam int MARK_WIDTH         = 21;
    localparam int CHANNELS           = 6;
    localparam logic [15:0] IRQ_TICKS_RST = 16'h0B46;

    typedef struct packed {
        logic [15:0] carrier_cycle_count;
        logic [15:0] code_phase;
        logic [9:0]  millisecond_epoch_count;
        logic [4:0]  databit_epoch_count;
    } ttm_meas_t;

    typedef struct packed {
        logic        deferred_load_select;
        logic        dither_late;
        logic [5:0]  code_select;
    } ttm_ctrl_t;
endpackage

// ### design/ttm_divider.sv
// programmable divider producing a one-cycle enable pulse
// assumes en_i is a same-clock enable
`timescale 1ns/10ps
module ttm_divider #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         resetn_i,
    // control
    input  wire logic         en_i,
    input  wire logic         restart_i,
    input  wire logic [W-1:0] period_i,
    // pulse
    output logic              pulse_o
);
    logic [W-1:0] cnt_q;
    wire          wrap = en_i && (cnt_q >= period_i - W'(1));

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
        end else if (restart_i) begin
            cnt_q <= '0;
        end else if (wrap) begin
            cnt_q <= '0;
        end else if (en_i) begin
            cnt_q <= cnt_q + W'(1);
        end
    end
    assign pulse_o = wrap;
endmodule

// ### design/ttm_channel.sv
// one tracking channel: measurement holding, protection, preset
// assumes strobe and host strobes are single-cycle, same clock
`timescale 1ns/10ps
module ttm_channel (
    // clock and reset
    input  wire logic               core_clk_i,
    input  wire logic               resetn_i,
    // timing
    input  wire logic               strobe_i,
    input  wire logic               ms_tick_i,
    // live channel state
    input  wire ttm_pkg::ttm_meas_t live_i,
    input  wire logic               slewing_i,
    // host
    input  wire logic               ctrl_wr_i,
    input  wire ttm_pkg::ttm_ctrl_t ctrl_i,
    input  wire logic               slew_wr_i,
    input  wire logic [15:0]        slew_i,
    input  wire logic               ms_epoch_wr_i,
    input  wire logic [9:0]         ms_epoch_i,
    input  wire logic               bit_epoch_wr_i,
    input  wire logic [4:0]         bit_epoch_i,
    input  wire logic               cycle_rd_i,
    input  wire logic               meas_clear_i,
    // outputs
    output ttm_pkg::ttm_meas_t      held_o,
    output ttm_pkg::ttm_ctrl_t      ctrl_o,
    output logic [15:0]             slew_o,
    output logic                    slew_go_o,
    output logic [9:0]              ms_epoch_o,
    output logic [4:0]              bit_epoch_o,
    output logic                    dither_late_o,
    output logic                    fresh_o,
    output logic                    missed_o,
    output logic                    slewed_o
);
    ttm_pkg::ttm_meas_t held_q;
    ttm_pkg::ttm_ctrl_t ctrl_q, pend_q;
    logic [15:0] slew_q, pslew_q;
    logic [9:0]  ms_q, pms_q;
    logic [4:0]  bit_q, pbit_q;
    logic        armed_q, fresh_q, prot_q, missed_q, slewed_q, slewacc_q, go_q, pslew_v_q;

    wire preset_mode = pend_q.deferred_load_select;
    wire do_preset   = strobe_i && armed_q;
    wire release_p   = cycle_rd_i || meas_clear_i;
    wire ms_wrap     = ms_tick_i && (ms_q == 10'd19);

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            held_q <= '0; ctrl_q <= '0; pend_q <= '0; slew_q <= '0; pslew_q <= '0;
            ms_q <= '0; pms_q <= '0; bit_q <= '0; pbit_q <= '0; armed_q <= 1'b0;
            fresh_q <= 1'b0; prot_q <= 1'b0; missed_q <= 1'b0; slewed_q <= 1'b0;
            slewacc_q <= 1'b0; go_q <= 1'b0; pslew_v_q <= 1'b0;
        end else begin
            go_q <= 1'b0;
            if (ctrl_wr_i) begin
                pend_q <= ctrl_i;
                if (!ctrl_i.deferred_load_select) ctrl_q <= ctrl_i;
            end
            if (slew_wr_i && preset_mode) begin pslew_q <= slew_i; pslew_v_q <= 1'b1; end
            else if (slew_wr_i) begin slew_q <= slew_i; go_q <= 1'b1; end
            if (ms_epoch_wr_i && preset_mode) pms_q <= ms_epoch_i;
            else if (ms_epoch_wr_i) ms_q <= ms_epoch_i;
            else if (ms_tick_i) ms_q <= ms_wrap ? 10'd0 : ms_q + 10'd1;
            if (bit_epoch_wr_i && preset_mode) begin pbit_q <= bit_epoch_i; armed_q <= 1'b1; end
            else if (bit_epoch_wr_i) bit_q <= bit_epoch_i;
            else if (ms_wrap) bit_q <= bit_q + 5'd1;
            slewacc_q <= slewacc_q | slewing_i | slew_wr_i;
            if (do_preset) begin
                ctrl_q <= pend_q;
                pend_q.deferred_load_select <= 1'b0;
                ctrl_q.deferred_load_select <= 1'b0;
                ms_q <= pms_q; bit_q <= pbit_q; armed_q <= 1'b0;
                if (pslew_v_q) begin slew_q <= pslew_q; go_q <= 1'b1; end
                pslew_v_q <= 1'b0;
            end
            if (strobe_i && !prot_q) begin
                held_q <= live_i;
                slewed_q <= slewacc_q | slewing_i;
                slewacc_q <= 1'b0;
                fresh_q <= 1'b1;
                prot_q  <= 1'b1;
            end else if (strobe_i) begin
                missed_q <= 1'b1;
                if (do_preset) prot_q <= 1'b1;
            end else if (release_p) begin
                fresh_q <= 1'b0;
                prot_q  <= 1'b0;
            end
            if (meas_clear_i && !strobe_i) missed_q <= 1'b0;
        end
    end

    assign held_o        = held_q;
    assign ctrl_o        = ctrl_q;
    assign slew_o        = slew_q;
    assign slew_go_o     = go_q;
    assign ms_epoch_o    = ms_q;
    assign bit_epoch_o   = bit_q;
    assign dither_late_o = ctrl_q.dither_late ^ ms_q[0];
    assign fresh_o       = fresh_q;
    assign missed_o      = missed_q;
    assign slewed_o      = slewed_q;
endmodule

// ### design/ttm_top.sv
// tracking timebase and measurement control top level
// assumes host strobes are synchronous single-cycle pulses
`timescale 1ns/10ps
module ttm_top #(
    parameter int CH = ttm_pkg::CHANNELS
) (
    // clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   resetn_i,
    // timebase control
    input  wire logic                   timebase_wr_i,
    input  wire logic [15:0]            irq_ticks_i,
    input  wire logic [7:0]             irqs_per_strobe_i,
    input  wire logic                   irq_output_gate_i,
    input  wire logic                   int_source_i,
    // pins
    input  wire logic                   irq_in_i,
    input  wire logic                   rtc_irq_i,
    // time mark
    input  wire logic                   mark_wr_i,
    input  wire logic [ttm_pkg::MARK_WIDTH-1:0] mark_count_i,
    // channel host access
    input  wire logic [CH-1:0]          ctrl_wr_i,
    input  wire ttm_pkg::ttm_ctrl_t     ctrl_i,
    input  wire logic [CH-1:0]          slew_wr_i,
    input  wire logic [15:0]            slew_i,
    input  wire logic [CH-1:0]          ms_epoch_wr_i,
    input  wire logic [9:0]             ms_epoch_i,
    input  wire logic [CH-1:0]          bit_epoch_wr_i,
    input  wire logic [4:0]             bit_epoch_i,
    input  wire logic [CH-1:0]          cycle_rd_i,
    input  wire logic [CH-1:0]          meas_clear_i,
    input  wire ttm_pkg::ttm_meas_t [CH-1:0] live_i,
    input  wire logic [CH-1:0]          slewing_i,
    // outputs
    output logic                        irq_o,
    output logic                        strobe_o,
    output logic                        sample_o,
    output logic                        mark_o,
    output logic [15:0]                 rtc_delay_o,
    output logic [15:0]                 measurement_flags_primary_o,
    output logic [15:0]                 measurement_flags_secondary_o,
    output ttm_pkg::ttm_meas_t [CH-1:0] held_o,
    output logic [CH-1:0]               dither_late_o,
    output logic [CH-1:0]               slew_go_o
);
    // --------------------------------------------------------
    // time base
    // --------------------------------------------------------
    logic [15:0] irq_ticks_q;
    logic [7:0]  per_strobe_q;
    logic        gate_q, src_q, irq_q, strobe_q;
    logic        base_en, irq_p, strobe_p;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_ticks_q  <= ttm_pkg::IRQ_TICKS_RST;
            per_strobe_q <= 8'(ttm_pkg::STROBE_100MS_IRQS);
            gate_q <= 1'b0;
            src_q  <= 1'b0;
        end else if (timebase_wr_i) begin
            irq_ticks_q  <= irq_ticks_i;
            per_strobe_q <= irqs_per_strobe_i;
            gate_q <= irq_output_gate_i;
            src_q  <= int_source_i;
        end
    end

    ttm_divider #(.W(8)) u_base (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .en_i(1'b1),
        .restart_i(timebase_wr_i), .period_i(8'(ttm_pkg::BASE_TICK_CYC)), .pulse_o(base_en));
    ttm_divider #(.W(16)) u_irq (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .en_i(base_en),
        .restart_i(timebase_wr_i), .period_i(irq_ticks_q), .pulse_o(irq_p));
    // strobe derived from the same chain, so it always lands on an irq pulse
    ttm_divider #(.W(8)) u_strobe (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .en_i(irq_p),
        .restart_i(timebase_wr_i), .period_i(per_strobe_q), .pulse_o(strobe_p));

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_q <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            irq_q <= irq_p && gate_q;
            strobe_q <= strobe_p;
        end
    end
    assign irq_o    = irq_q;
    assign strobe_o = strobe_q;

    // --------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------
    logic [2:0] irqin_s, rtc_s;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irqin_s <= '0;
            rtc_s <= '0;
        end else begin
            irqin_s <= {irqin_s[1:0], irq_in_i};
            rtc_s <= {rtc_s[1:0], rtc_irq_i};
        end
    end
    wire irqin_edge = irqin_s[1] && !irqin_s[2];
    wire rtc_edge   = rtc_s[1] && !rtc_s[2];
    assign sample_o = src_q ? irq_q : irqin_edge;

    // --------------------------------------------------------
    // external clock delay counter
    // --------------------------------------------------------
    logic        rtc_run_q, rtc_seen_q, rtc_tick;
    logic [15:0] rtc_cnt_q, rtc_hold_q;
    ttm_divider #(.W(9)) u_rtc (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .en_i(rtc_run_q),
        .restart_i(rtc_edge), .period_i(9'(ttm_pkg::RTC_TICK_CYC)), .pulse_o(rtc_tick));
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rtc_run_q <= 1'b0; rtc_cnt_q <= '0; rtc_hold_q <= '0; rtc_seen_q <= 1'b0;
        end else begin
            if (rtc_edge) begin
                rtc_run_q <= 1'b1; rtc_cnt_q <= '0; rtc_seen_q <= 1'b1;
            end else if (strobe_q && rtc_run_q) begin
                rtc_hold_q <= rtc_cnt_q; rtc_run_q <= 1'b0;
            end else if (rtc_tick) begin
                rtc_cnt_q <= rtc_cnt_q + 16'd1;
            end
            if (|meas_clear_i && !rtc_edge) rtc_seen_q <= 1'b0;
        end
    end
    assign rtc_delay_o = rtc_hold_q;

    // --------------------------------------------------------
    // second mark generator
    // --------------------------------------------------------
    logic [ttm_pkg::MARK_WIDTH-1:0] mark_load_q, mark_cnt_q;
    logic mark_arm_q, mark_run_q, step_en, mark_q;
    logic [2:0] fix_q;
    ttm_divider #(.W(4)) u_step (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .en_i(mark_run_q),
        .restart_i(strobe_q), .period_i(4'(ttm_pkg::MARK_STEP_CYC)), .pulse_o(step_en));
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mark_load_q <= '0; mark_cnt_q <= '0; mark_arm_q <= 1'b0;
            mark_run_q <= 1'b0; fix_q <= '0; mark_q <= 1'b0;
        end else begin
            mark_q <= 1'b0;
            if (mark_wr_i) begin mark_load_q <= mark_count_i; mark_arm_q <= 1'b1; end
            if (strobe_q && mark_arm_q && !mark_wr_i) begin
                mark_cnt_q <= mark_load_q; mark_run_q <= 1'b1; mark_arm_q <= 1'b0;
            end else if (mark_run_q && step_en) begin
                // stop on one, so a count of n gives n steps; zero still costs one step
                if (mark_cnt_q[ttm_pkg::MARK_WIDTH-1:1] == '0) begin
                    mark_run_q <= 1'b0;
                    fix_q <= 3'(ttm_pkg::MARK_FIXED_CYC);
                end else mark_cnt_q <= mark_cnt_q - 1'b1;
            end
            if (fix_q != 3'd0) begin
                fix_q <= fix_q - 3'd1;
                mark_q <= (fix_q == 3'd1);
            end
        end
    end
    assign mark_o = mark_q;

    // --------------------------------------------------------
    // channels
    // --------------------------------------------------------
    logic ms_tick;
    logic [CH-1:0] fresh, missed, slewed;
    ttm_divider #(.W(8)) u_ms (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .en_i(base_en),
        .restart_i(1'b0), .period_i(8'd160), .pulse_o(ms_tick));
    for (genvar c = 0; c < CH; c++) begin : g_ch
        ttm_channel u_ch (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .strobe_i(strobe_q),
            .ms_tick_i(ms_tick), .live_i(live_i[c]), .slewing_i(slewing_i[c]), .ctrl_wr_i(ctrl_wr_i[c]),
            .ctrl_i(ctrl_i), .slew_wr_i(slew_wr_i[c]), .slew_i(slew_i), .ms_epoch_wr_i(ms_epoch_wr_i[c]),
            .ms_epoch_i(ms_epoch_i), .bit_epoch_wr_i(bit_epoch_wr_i[c]), .bit_epoch_i(bit_epoch_i),
            .cycle_rd_i(cycle_rd_i[c]), .meas_clear_i(meas_clear_i[c]), .held_o(held_o[c]),
            .ctrl_o(), .slew_o(), .slew_go_o(slew_go_o[c]), .ms_epoch_o(), .bit_epoch_o(),
            .dither_late_o(dither_late_o[c]), .fresh_o(fresh[c]), .missed_o(missed[c]),
            .slewed_o(slewed[c]));
    end
    assign measurement_flags_primary_o   = 16'(fresh);
    assign measurement_flags_secondary_o = {1'b0, rtc_seen_q, 2'b00, 6'(slewed), 6'(missed)};
endmodule

// ### tb/ttm_checker.sv
// port-level checks for the tracking timebase block
// assumes one clock domain, bound onto ttm_top
`timescale 1ns/10ps
module ttm_checker #(
    parameter int CH = 6
) (
    input wire logic                        core_clk_i,
    input wire logic                        resetn_i,
    input wire logic                        timebase_wr_i,
    input wire logic                        irq_output_gate_i,
    input wire logic                        rtc_irq_i,
    input wire logic [CH-1:0]               cycle_rd_i,
    input wire logic [CH-1:0]               meas_clear_i,
    input wire logic                        irq_o,
    input wire logic                        strobe_o,
    input wire logic                        mark_o,
    input wire logic [15:0]                 measurement_flags_primary_o,
    input wire logic [15:0]                 measurement_flags_secondary_o,
    input wire ttm_pkg::ttm_meas_t [CH-1:0] held_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // ------------------------------------------------------------
    // helper: last written gate level
    // ------------------------------------------------------------
    logic gate_q;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) gate_q <= 1'b0;
        else if (timebase_wr_i) gate_q <= irq_output_gate_i;
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_gate_forces_low: assert property ((!gate_q && !$past(gate_q)) |-> !irq_o)
        else $error("irq output high while gated off");
    a_strobe_sets_fresh: assert property (strobe_o |=> measurement_flags_primary_o[CH-1:0] == {CH{1'b1}})
        else $error("fresh flags not all set after strobe");
    a_read_clears_fresh: assert property ((|cycle_rd_i) && !strobe_o |=>
        (measurement_flags_primary_o[CH-1:0] & $past(cycle_rd_i)) == '0)
        else $error("fresh flag survived cycle read");
    a_held_only_strobe: assert property (!strobe_o |=> $stable(held_o))
        else $error("held data moved without strobe");
    a_protect_missed: assert property (strobe_o && measurement_flags_primary_o[0] && !cycle_rd_i[0]
        && !meas_clear_i[0] |=> measurement_flags_secondary_o[0] && $stable(held_o[0]))
        else $error("protected channel overwritten or missed flag absent");
    a_missed_sticky: assert property (measurement_flags_secondary_o[0] && !meas_clear_i[0]
        |=> measurement_flags_secondary_o[0])
        else $error("missed flag dropped without clear");
    a_rtc_seen_flag: assert property ($rose(rtc_irq_i) && meas_clear_i == '0
        |-> ##[1:6] measurement_flags_secondary_o[14])
        else $error("external clock seen flag not set");
    a_strobe_single: assert property (strobe_o |=> !strobe_o)
        else $error("strobe wider than one cycle");
    a_mark_single: assert property (mark_o |=> !mark_o)
        else $error("mark wider than one cycle");
    c_strobe: cover property (strobe_o);
    c_mark: cover property (mark_o);
    c_missed: cover property (measurement_flags_secondary_o[0]);
endmodule

// ### tb/ttm_chan_model.sv
// channel-side model supplying live measurement state
// assumes advance_i is a one-cycle pulse from the bench
`timescale 1ns/10ps
module ttm_chan_model (
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  resetn_i,
    // control
    input  wire logic                  advance_i,
    input  wire logic [5:0]            slew_req_i,
    // live state
    output ttm_pkg::ttm_meas_t [5:0]   live_o,
    output logic [5:0]                 slewing_o
);
    logic [15:0] cnt_q;
    // values move only on demand, so the bench knows what a strobe sees
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) cnt_q <= 16'h1230;
        else if (advance_i) cnt_q <= cnt_q + 16'h0101;
    end
    for (genvar g = 0; g < 6; g++) begin : g_ch
        assign live_o[g] = {cnt_q + 16'(g), ~cnt_q, cnt_q[9:0], cnt_q[4:0]};
    end
    assign slewing_o = slew_req_i;
endmodule

// ### tb/ttm_top_bench.sv
// self-checking bench for ttm_top
// assumes checker and channel model compiled before this file
`timescale 1ns/10ps
module ttm_top_bench;
    localparam int CH = 6;
    logic core_clk_i, resetn_i, tb_wr, gate, src, irq_in, rtc_irq, mark_wr, adv;
    logic [15:0] ticks, slew, rtc_delay, fa, fb;
    logic [7:0] ips;
    logic [20:0] mcount;
    logic [CH-1:0] ctrl_wr, slew_wr, ms_wr, bit_wr, cyc_rd, mclr, sreq, slewing, dlate, sgo;
    ttm_pkg::ttm_ctrl_t ctrl;
    logic [9:0] ms_ep;
    logic [4:0] bit_ep;
    ttm_pkg::ttm_meas_t [CH-1:0] live, held;
    logic irq_o, strobe_o, sample_o, mark_o;
    int fails = 0, n_tests = 0;
    ttm_top #(.CH(CH)) uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .timebase_wr_i(tb_wr),
        .irq_ticks_i(ticks), .irqs_per_strobe_i(ips), .irq_output_gate_i(gate), .int_source_i(src),
        .irq_in_i(irq_in), .rtc_irq_i(rtc_irq), .mark_wr_i(mark_wr), .mark_count_i(mcount),
        .ctrl_wr_i(ctrl_wr), .ctrl_i(ctrl), .slew_wr_i(slew_wr), .slew_i(slew), .ms_epoch_wr_i(ms_wr),
        .ms_epoch_i(ms_ep), .bit_epoch_wr_i(bit_wr), .bit_epoch_i(bit_ep), .cycle_rd_i(cyc_rd),
        .meas_clear_i(mclr), .live_i(live), .slewing_i(slewing), .irq_o(irq_o), .strobe_o(strobe_o),
        .sample_o(sample_o), .mark_o(mark_o), .rtc_delay_o(rtc_delay), .measurement_flags_primary_o(fa),
        .measurement_flags_secondary_o(fb), .held_o(held), .dither_late_o(dlate), .slew_go_o(sgo));
    ttm_chan_model u_model (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .advance_i(adv),
        .slew_req_i(sreq), .live_o(live), .slewing_o(slewing));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tick(input int n = 1);
        repeat (n) begin @(posedge core_clk_i); #1; end
    endtask
    task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin fails++; $display("[ERR] %s expected %0h seen %0h", what, exp, got); end
    endtask
    // trailing idle cycle keeps two pulses from meeting in one time step
    task automatic pulse(ref logic [CH-1:0] v, input int c);
        v[c] = 1'b1; tick(); v[c] = 1'b0; tick();
    endtask
    task automatic step(ref logic s);
        s = 1'b1; tick(); s = 1'b0; tick();
    endtask
    task automatic wait_strobe(output int cyc);
        cyc = 0;
        do begin tick(); cyc++; end while (strobe_o !== 1'b1 && cyc < 3000);
        chk("strobe seen", cyc < 3000, 1'b1);
    endtask
    task automatic read_all();
        for (int c = 0; c < CH; c++) pulse(cyc_rd, c);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        int n = 0;
        repeat (300) begin tick(); if (irq_o === 1'b1) n++; end
        chk("irq pulses gated", n, 0);
        chk("fresh after reset", fa, 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_timebase();
        int n = 0, k;
        ticks = 16'h0004; ips = 8'h0A; gate = 1'b1; src = 1'b0;
        step(tb_wr);
        wait_strobe(k);
        do begin tick(); if (irq_o === 1'b1) n++; end while (strobe_o !== 1'b1 && n < 40);
        chk("irqs per strobe", n, 10);
        n = 0;
        irq_in = 1'b1;
        repeat (8) begin tick(); if (sample_o === 1'b1) n++; end
        irq_in = 1'b0;
        chk("sample on pin edge", n > 0, 1'b1);
        src = 1'b1; n = 0;
        step(tb_wr);
        repeat (200) begin tick(); if (sample_o === 1'b1) n++; end
        chk("sample on irq out", n > 0, 1'b1);
        $display("timebase test done");
    endtask
    task automatic t_protect();
        int k;
        ttm_pkg::ttm_meas_t old0;
        wait_strobe(k); tick(); read_all();
        step(adv); sreq[2] = 1'b1;
        wait_strobe(k); tick();
        for (int c = 0; c < CH; c++) chk("held latch", held[c], live[c]);
        chk("fresh all", fa[5:0], 6'h3F);
        old0 = held[0];
        for (int c = 1; c < CH; c++) pulse(cyc_rd, c);
        chk("fresh after reads", fa[5:0], 6'h01);
        step(adv);
        wait_strobe(k); tick(); sreq[2] = 1'b0;
        chk("protected held", held[0], old0);
        chk("unprotected held", held[1], live[1]);
        chk("missed flag", fb[0], 1'b1);
        chk("slewed flag", fb[8], 1'b1);
        pulse(cyc_rd, 0);
        chk("fresh cleared", fa[0], 1'b0);
        pulse(mclr, 0);
        chk("missed cleared", fb[0], 1'b0);
        read_all();
        $display("protect test done");
    endtask
    task automatic t_preset();
        int k;
        ttm_pkg::ttm_meas_t old1;
        wait_strobe(k); tick(); read_all();
        ctrl = '{deferred_load_select: 1'b0, dither_late: 1'b0, code_select: 6'h05};
        pulse(ctrl_wr, 1); ms_ep = 10'h000; pulse(ms_wr, 1); tick(2);
        chk("dither update", dlate[1], 1'b0);
        ctrl = '{deferred_load_select: 1'b1, dither_late: 1'b1, code_select: 6'h11};
        pulse(ctrl_wr, 1);
        slew = 16'h0010; pulse(slew_wr, 1);
        ms_ep = 10'h002; pulse(ms_wr, 1);
        bit_ep = 5'h03; pulse(bit_wr, 1);
        chk("dither held", dlate[1], 1'b0);
        step(adv);
        wait_strobe(k); tick();
        chk("dither preset", dlate[1], 1'b1);
        chk("slew at strobe", sgo[1], 1'b1);
        chk("preset latch", held[1], live[1]);
        ms_ep = 10'h003; pulse(ms_wr, 1); tick(2);
        chk("back to update", dlate[1], 1'b0);
        for (int c = 0; c < CH; c++) if (c != 1) pulse(cyc_rd, c);
        old1 = held[1];
        step(adv);
        wait_strobe(k); tick();
        chk("no acquire", held[1], old1);
        pulse(mclr, 1); read_all(); pulse(mclr, 1);
        step(adv);
        wait_strobe(k); tick();
        chk("acquire again", held[1], live[1]);
        read_all();
        $display("preset test done");
    endtask
    task automatic t_rtc();
        int k, e;
        wait_strobe(k); tick(4);
        rtc_irq = 1'b1;
        wait_strobe(k); tick(); rtc_irq = 1'b0;
        e = (k + 1) / ttm_pkg::RTC_TICK_CYC;
        chk("rtc delay", (int'(rtc_delay) >= e - 1) && (int'(rtc_delay) <= e + 1), 1'b1);
        chk("rtc seen", fb[14], 1'b1);
        read_all(); pulse(mclr, 0);
        $display("rtc test done");
    endtask
    task automatic t_mark();
        int k, n = 0, e;
        wait_strobe(k); tick();
        mcount = 21'h000005; step(mark_wr);
        e = 5 * ttm_pkg::MARK_STEP_CYC + ttm_pkg::MARK_FIXED_CYC + 1;
        wait_strobe(k);
        do begin tick(); n++; end while (mark_o !== 1'b1 && n < 300);
        chk("mark delay", (n >= e - 2) && (n <= e + 2), 1'b1);
        $display("mark test done");
    endtask
    // ------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    initial begin
        {resetn_i, tb_wr, gate, src, irq_in, rtc_irq, mark_wr, adv} = '0;
        {ticks, slew, ips, mcount, ms_ep, bit_ep} = '0;
        {ctrl_wr, slew_wr, ms_wr, bit_wr, cyc_rd, mclr, sreq} = '0;
        ctrl = '0;
        repeat (12) @(posedge core_clk_i);
        #1 resetn_i = 1'b1;
        t_reset(); t_timebase(); t_protect(); t_preset(); t_rtc(); t_mark();
        conclude();
    end
    // about twelve strobes of 880 cycles are expected
    initial begin
        #(40000 * 8);
        fails++;
        conclude();
    end
endmodule
bind ttm_top ttm_checker #(.CH(CH)) u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .timebase_wr_i(timebase_wr_i), .irq_output_gate_i(irq_output_gate_i), .rtc_irq_i(rtc_irq_i),
    .cycle_rd_i(cycle_rd_i), .meas_clear_i(meas_clear_i), .irq_o(irq_o), .strobe_o(strobe_o),
    .mark_o(mark_o), .measurement_flags_primary_o(measurement_flags_primary_o),
    .measurement_flags_secondary_o(measurement_flags_secondary_o), .held_o(held_o));
